//--- shared/ifc_pkg.sv
package ifc_pkg;

    // ****************************************
    // bus and data widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BUF_COUNT_W = 7;
    localparam int IRQ_W = 4;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_BUF_STATUS = 8'h0d;
    localparam logic [7:0] ADDR_FILL_TX = 8'h0e;
    localparam logic [7:0] ADDR_ALERT_LEVEL = 8'h0f;
    localparam logic [7:0] ADDR_MODE_CFG = 8'h20;
    localparam logic [7:0] ADDR_BUF_LEVEL = 8'h21;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h22;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h23;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FT_FILL_METHOD = 7;
    localparam int FT_LOAD_ACTIVE = 6;
    localparam int FT_TX_DONE = 5;
    localparam int FT_LAUNCH = 4;
    localparam int FT_ALERT_EN = 3;
    localparam int FT_ALERT_FLAG = 2;
    localparam int FT_LOCK_FLAG = 1;
    localparam int FT_LOCK_EN = 0;
    localparam int BS_FULL = 2;
    localparam int BS_NOT_EMPTY = 1;
    localparam int BS_OVERFLOW = 0;
    localparam int EV_TX_DONE = 0;
    localparam int EV_ALERT = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_FILL_START = 3;

    // ****************************************
    // reset values and scale
    // ****************************************
    localparam logic [7:0] FILL_TX_RESET = 8'h01;
    localparam logic [7:0] ALERT_LEVEL_RESET = 8'h00;
    localparam logic [7:0] BUF_LEVEL_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int STRENGTH_MILLI_DB_PER_LSB = 500;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_BUF = 2'b01,
        MODE_PKT = 2'b10,
        MODE_PKT_ALT = 2'b11
    } ifc_mode_t;

    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_ARMED = 2'b01,
        FS_FILLING = 2'b10
    } ifc_fill_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ifc_bus_req_t;

    typedef struct packed {
        logic [6:0] count;
        logic full;
        logic empty;
        logic overrun;
    } ifc_buf_stat_t;

endpackage : ifc_pkg

//--- verilog/ifc_tx_launch.sv
`timescale 1ns/1ns
module ifc_tx_launch (
    input wire ifc_pkg::ifc_mode_t mode, // data handling mode
    input wire logic launchOnAny, // launch condition bit
    input wire ifc_pkg::ifc_buf_stat_t bufStat, // buffer state
    input wire logic [7:0] levelSetting, // buffer level setting
    output logic launchOk, // transmit may start
    output logic irq0Src // source for interrupt pin zero
);

    logic notEmpty;
    logic levelReached;

    // ****************************************
    // launch condition and pin zero source
    // ****************************************
    always_comb begin
        notEmpty = !bufStat.empty;
        levelReached = {1'b0, bufStat.count} >= levelSetting;
        launchOk = 1'b0;
        irq0Src = 1'b0;
        if (mode == ifc_pkg::MODE_BUF) begin
            launchOk = launchOnAny ? notEmpty : bufStat.full;
            irq0Src = notEmpty;
        end else if (mode[1]) begin
            launchOk = launchOnAny ? notEmpty : levelReached;
            irq0Src = launchOnAny ? notEmpty : levelReached;
        end
    end

endmodule : ifc_tx_launch

//--- verilog/ifc_status_ctrl.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module ifc_status_ctrl (
    input wire logic sys_clk, // 50 MHz clock
    input wire logic rst, // asynchronous reset, active high
    input wire ifc_pkg::ifc_bus_req_t busReq, // register access
    output logic [7:0] rdata, // read data, cycle after read
    input wire logic syncDetected, // sync word found pulse
    input wire ifc_pkg::ifc_buf_stat_t bufStat, // buffer state
    output logic bufFillEn, // buffer accepts received bytes
    output logic bufFlush, // one-cycle buffer clear
    input wire logic txMode, // transmitter active
    input wire logic shiftDone, // last bit left shift register
    output logic txStart, // transmit launch level
    output logic irq0, // interrupt pin zero level
    input wire logic [7:0] strength, // received strength, half dB steps
    input wire logic pllLocked, // synthesizer lock detect
    output logic lockPinOut, // lock pin value
    output logic lockPinOe, // lock pin drive enable
    output logic irq // combined interrupt level
);

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] fillTx_reg, fillTx_next;
    logic [7:0] alertLevel_reg, alertLevel_next;
    logic [7:0] bufLevel_reg, bufLevel_next;
    ifc_pkg::ifc_mode_t mode_reg, mode_next;
    logic overflow_reg, overflow_next;
    logic [3:0] irqStatus_reg, irqStatus_next;
    logic [3:0] irqMask_reg, irqMask_next;
    ifc_pkg::ifc_fill_state_t fill_reg, fill_next;
    logic [7:0] rdata_reg, rdata_next;
    logic flush_reg, flush_next;
    logic txStart_reg, txStart_next;
    logic irq0_reg, irq0_next;
    logic txStartRaw, irq0Raw;
    logic wrFt, wrBs, buffered, manual, alertHit, fillStart;
    logic [3:0] events;

    ifc_tx_launch launch (
        .mode(mode_reg),
        .launchOnAny(fillTx_reg[ifc_pkg::FT_LAUNCH]),
        .bufStat(bufStat),
        .levelSetting(bufLevel_reg),
        .launchOk(txStartRaw),
        .irq0Src(irq0Raw)
    );

    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        wrFt = busReq.wr && busReq.addr == ifc_pkg::ADDR_FILL_TX;
        wrBs = busReq.wr && busReq.addr == ifc_pkg::ADDR_BUF_STATUS;
        buffered = mode_reg == ifc_pkg::MODE_BUF;
        manual = fillTx_reg[ifc_pkg::FT_FILL_METHOD];
        // level is coded like the strength reading, so compare raw
        alertHit = fillTx_reg[ifc_pkg::FT_ALERT_EN]
            && strength > alertLevel_reg;
    end

    // ****************************************
    // buffer fill control
    // ****************************************
    always_comb begin
        fill_next = fill_reg;
        fillStart = 1'b0;
        if (!buffered) begin
            fill_next = ifc_pkg::FS_IDLE;
        end else if (manual) begin
            if (wrFt) begin
                fill_next = busReq.wdata[ifc_pkg::FT_LOAD_ACTIVE]
                    ? ifc_pkg::FS_FILLING : ifc_pkg::FS_IDLE;
            end else if (fill_reg == ifc_pkg::FS_ARMED) begin
                fill_next = ifc_pkg::FS_IDLE;
            end
        end else begin
            case (fill_reg)
                ifc_pkg::FS_IDLE: begin
                    fill_next = ifc_pkg::FS_ARMED;
                end
                ifc_pkg::FS_ARMED: begin
                    if (syncDetected) begin
                        fill_next = ifc_pkg::FS_FILLING;
                        fillStart = 1'b1;
                    end
                end
                ifc_pkg::FS_FILLING: begin
                    // a sync in the clearing cycle keeps the fill running, with no rearm
                    if (wrFt && busReq.wdata[ifc_pkg::FT_LOAD_ACTIVE]
                        && !overflow_reg && !syncDetected) begin
                        fill_next = ifc_pkg::FS_ARMED;
                    end
                end
                default: begin
                    fill_next = ifc_pkg::FS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // configuration and flags
    // ****************************************
    always_comb begin
        fillTx_next = fillTx_reg;
        alertLevel_next = alertLevel_reg;
        bufLevel_next = bufLevel_reg;
        mode_next = mode_reg;
        overflow_next = overflow_reg;
        irqMask_next = irqMask_reg;
        flush_next = 1'b0;
        if (wrFt) begin
            fillTx_next[ifc_pkg::FT_FILL_METHOD] =
                busReq.wdata[ifc_pkg::FT_FILL_METHOD];
            fillTx_next[ifc_pkg::FT_LAUNCH] =
                busReq.wdata[ifc_pkg::FT_LAUNCH];
            fillTx_next[ifc_pkg::FT_ALERT_EN] =
                busReq.wdata[ifc_pkg::FT_ALERT_EN];
            fillTx_next[ifc_pkg::FT_LOCK_EN] =
                busReq.wdata[ifc_pkg::FT_LOCK_EN];
            if (busReq.wdata[ifc_pkg::FT_ALERT_FLAG]) begin
                fillTx_next[ifc_pkg::FT_ALERT_FLAG] = 1'b0;
            end
            if (busReq.wdata[ifc_pkg::FT_LOCK_FLAG]) begin
                fillTx_next[ifc_pkg::FT_LOCK_FLAG] = 1'b0;
            end
        end
        if (wrBs && busReq.wdata[ifc_pkg::BS_OVERFLOW]) begin
            overflow_next = 1'b0;
            flush_next = 1'b1;
        end
        // sets come last so an event in a clear cycle is kept
        if (bufStat.overrun) begin
            overflow_next = 1'b1;
        end
        if (alertHit) begin
            fillTx_next[ifc_pkg::FT_ALERT_FLAG] = 1'b1;
        end
        if (pllLocked) begin
            fillTx_next[ifc_pkg::FT_LOCK_FLAG] = 1'b1;
        end
        // read-only done flag drops when the next launch begins
        if (txStart_reg) begin
            fillTx_next[ifc_pkg::FT_TX_DONE] = 1'b0;
        end
        if (shiftDone) begin
            fillTx_next[ifc_pkg::FT_TX_DONE] = 1'b1;
        end
        fillTx_next[ifc_pkg::FT_LOAD_ACTIVE] =
            fill_next == ifc_pkg::FS_FILLING;
        if (busReq.wr && busReq.addr == ifc_pkg::ADDR_ALERT_LEVEL) begin
            alertLevel_next = busReq.wdata;
        end
        if (busReq.wr && busReq.addr == ifc_pkg::ADDR_BUF_LEVEL) begin
            bufLevel_next = busReq.wdata;
        end
        if (busReq.wr && busReq.addr == ifc_pkg::ADDR_MODE_CFG) begin
            mode_next = ifc_pkg::ifc_mode_t'(busReq.wdata[1:0]);
        end
        if (busReq.wr && busReq.addr == ifc_pkg::ADDR_IRQ_MASK) begin
            irqMask_next = busReq.wdata[3:0];
        end
    end

    // ****************************************
    // interrupt status, launch, read data
    // ****************************************
    always_comb begin
        events = '0;
        events[ifc_pkg::EV_TX_DONE] = shiftDone;
        events[ifc_pkg::EV_ALERT] = alertHit;
        events[ifc_pkg::EV_OVERRUN] = bufStat.overrun;
        events[ifc_pkg::EV_FILL_START] = fillStart;
        irqStatus_next = irqStatus_reg;
        if (busReq.wr && busReq.addr == ifc_pkg::ADDR_IRQ_STATUS) begin
            irqStatus_next = irqStatus_reg & ~busReq.wdata[3:0];
        end
        irqStatus_next = irqStatus_next | events;
        txStart_next = txMode && txStartRaw;
        irq0_next = irq0Raw;
        rdata_next = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                ifc_pkg::ADDR_BUF_STATUS: begin
                    rdata_next = {5'h00, bufStat.full, !bufStat.empty,
                        overflow_reg};
                end
                ifc_pkg::ADDR_FILL_TX: rdata_next = fillTx_reg;
                ifc_pkg::ADDR_ALERT_LEVEL: rdata_next = alertLevel_reg;
                ifc_pkg::ADDR_MODE_CFG: rdata_next = {6'h00, mode_reg};
                ifc_pkg::ADDR_BUF_LEVEL: rdata_next = bufLevel_reg;
                ifc_pkg::ADDR_IRQ_STATUS: rdata_next = {4'h0, irqStatus_reg};
                ifc_pkg::ADDR_IRQ_MASK: rdata_next = {4'h0, irqMask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fillTx_reg <= ifc_pkg::FILL_TX_RESET;
            alertLevel_reg <= ifc_pkg::ALERT_LEVEL_RESET;
            bufLevel_reg <= ifc_pkg::BUF_LEVEL_RESET;
            mode_reg <= ifc_pkg::MODE_CONT;
            overflow_reg <= 1'b0;
            irqStatus_reg <= ifc_pkg::IRQ_RESET;
            irqMask_reg <= ifc_pkg::IRQ_RESET;
            fill_reg <= ifc_pkg::FS_IDLE;
            rdata_reg <= 8'h00;
            flush_reg <= 1'b0;
            txStart_reg <= 1'b0;
            irq0_reg <= 1'b0;
        end else begin
            fillTx_reg <= fillTx_next;
            alertLevel_reg <= alertLevel_next;
            bufLevel_reg <= bufLevel_next;
            mode_reg <= mode_next;
            overflow_reg <= overflow_next;
            irqStatus_reg <= irqStatus_next;
            irqMask_reg <= irqMask_next;
            fill_reg <= fill_next;
            rdata_reg <= rdata_next;
            flush_reg <= flush_next;
            txStart_reg <= txStart_next;
            irq0_reg <= irq0_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        rdata = rdata_reg;
        bufFillEn = buffered && fill_reg == ifc_pkg::FS_FILLING;
        bufFlush = flush_reg;
        txStart = txStart_reg;
        irq0 = irq0_reg;
        irq = |(irqStatus_reg & irqMask_reg);
        lockPinOut = pllLocked;
        lockPinOe = fillTx_reg[ifc_pkg::FT_LOCK_EN];
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_auto_fill_start: assert property (
        buffered && !manual && fill_reg == ifc_pkg::FS_ARMED && syncDetected
        && !busReq.wr |=> fillTx_reg[ifc_pkg::FT_LOAD_ACTIVE] && bufFillEn)
        else $error("auto fill did not start on sync");

    a_auto_rearm: assert property (
        buffered && !manual && fill_reg == ifc_pkg::FS_FILLING && wrFt
        && busReq.wdata[ifc_pkg::FT_LOAD_ACTIVE] && !overflow_reg
        && !syncDetected |=> !bufFillEn && fill_reg == ifc_pkg::FS_ARMED)
        else $error("load active not cleared by write");

    a_manual_fill: assert property (
        buffered && manual && wrFt
        |=> bufFillEn == $past(busReq.wdata[ifc_pkg::FT_LOAD_ACTIVE]))
        else $error("manual fill does not follow write");

    a_tx_done_set: assert property (
        shiftDone |=> fillTx_reg[ifc_pkg::FT_TX_DONE])
        else $error("transmit done not raised");

    a_buf_launch: assert property (
        txMode && mode_reg == ifc_pkg::MODE_BUF
        && !fillTx_reg[ifc_pkg::FT_LAUNCH] && bufStat.full
        |=> txStart)
        else $error("buffered launch missing on full");

    a_pkt_pin_zero: assert property (
        mode_reg[1] && fillTx_reg[ifc_pkg::FT_LAUNCH]
        && $stable(mode_reg) |=> irq0 == !$past(bufStat.empty))
        else $error("pin zero not showing non-empty");

    a_alert_sticky: assert property (
        alertHit ##1 !(wrFt && busReq.wdata[ifc_pkg::FT_ALERT_FLAG])
        |=> fillTx_reg[ifc_pkg::FT_ALERT_FLAG])
        else $error("alert flag lost before clear");

    a_lock_flag: assert property (
        pllLocked |=> fillTx_reg[ifc_pkg::FT_LOCK_FLAG])
        else $error("lock flag low while locked");

    a_lock_pin: assert property (
        wrFt |=> lockPinOe == $past(busReq.wdata[ifc_pkg::FT_LOCK_EN])
        && lockPinOut == pllLocked)
        else $error("lock pin not driven with lock state");

    a_overflow_clear: assert property (
        wrBs && busReq.wdata[ifc_pkg::BS_OVERFLOW] && !bufStat.overrun
        |=> bufFlush && !overflow_reg ##1 (!bufFlush || $past(wrBs)))
        else $error("overflow clear did not flush once");

    a_level_read: assert property (
        busReq.rd && busReq.addr == ifc_pkg::ADDR_ALERT_LEVEL
        |=> rdata == $past(alertLevel_reg))
        else $error("alert level read mismatch");

    c_fill_cycle: cover property (
        fill_reg == ifc_pkg::FS_ARMED ##1 fill_reg == ifc_pkg::FS_FILLING
        ##[1:20] fill_reg == ifc_pkg::FS_ARMED);
    c_tx_launch: cover property (txStart ##[1:50] shiftDone);
    c_alert_irq: cover property (alertHit ##2 irq);

endmodule : ifc_status_ctrl

//--- tb/irq_status_fifo_fill_control_tb_top.sv
`timescale 1ns/1ns
module irq_status_fifo_fill_control_tb_top;

    // ****************************************
    // signals
    // ****************************************
    logic sys_clk, rst, syncDetected, txMode, shiftDone, pllLocked;
    ifc_pkg::ifc_bus_req_t busReq;
    ifc_pkg::ifc_buf_stat_t bufStat;
    logic [7:0] rdata, strength, lvl, setting, v;
    logic bufFillEn, bufFlush, txStart, irq0, lockPinOut, lockPinOe, irq;
    logic [1:0] e;
    int mismatches, comparisons, c;

    ifc_status_ctrl ifc_status_ctrl_i (
        .sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdata(rdata),
        .syncDetected(syncDetected), .bufStat(bufStat),
        .bufFillEn(bufFillEn), .bufFlush(bufFlush), .txMode(txMode),
        .shiftDone(shiftDone), .txStart(txStart), .irq0(irq0),
        .strength(strength), .pllLocked(pllLocked),
        .lockPinOut(lockPinOut), .lockPinOe(lockPinOe), .irq(irq));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string n, input logic [7:0] seen,
            input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq.addr <= a;
        busReq.wdata <= d;
        busReq.wr <= 1'b1;
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
        #1;
    endtask : wr

    // data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic rdbit(input logic [7:0] a, input int b, input logic x,
            input string n);
        logic [7:0] r;
        rd(a, r);
        chk(n, r[b], x);
    endtask : rdbit

    task automatic settle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic set_count(input int k);
        @(posedge sys_clk);
        bufStat.count <= 7'(k);
        bufStat.full <= (k == 64);
        bufStat.empty <= (k == 0);
    endtask : set_count

    function automatic logic [1:0] exp_launch(input int m, input int l,
            input int k, input int s);
        logic ne, hit;
        ne = (k != 0);
        hit = l ? ne : (k >= s);
        if (m == 0) return 2'b00;
        if (m == 1) return {(l ? ne : (k == 64)), ne};
        return {hit, hit};
    endfunction : exp_launch

    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        busReq = '0;
        syncDetected = 1'b0;
        bufStat = '{count: 7'h00, full: 1'b0, empty: 1'b1, overrun: 1'b0};
        txMode = 1'b0;
        shiftDone = 1'b0;
        pllLocked = 1'b0;
        strength = 8'h00;
        void'($urandom(36));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ifc_pkg::ADDR_FILL_TX, v);
        chk("fill_tx reset", v, 8'h01);
        chk("lockPinOe reset", lockPinOe, 1'b1);
        rd(ifc_pkg::ADDR_ALERT_LEVEL, v);
        chk("alert level reset", v, 8'h00);
        settle(1);
        chk("rdata idle", rdata, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, v);
        chk("unmapped read", v, 8'h00);
        // lock flag sticks after lock is lost
        @(posedge sys_clk);
        pllLocked <= 1'b1;
        settle(2);
        chk("lockPinOut", lockPinOut, 1'b1);
        rdbit(ifc_pkg::ADDR_FILL_TX, 1, 1'b1, "lock flag");
        @(posedge sys_clk);
        pllLocked <= 1'b0;
        rdbit(ifc_pkg::ADDR_FILL_TX, 1, 1'b1, "lock flag held");
        wr(ifc_pkg::ADDR_FILL_TX, 8'h02);
        chk("lockPinOe off", lockPinOe, 1'b0);
        rdbit(ifc_pkg::ADDR_FILL_TX, 1, 1'b0, "lock flag clr");
        // strength alert against a random level
        lvl = 8'($urandom_range(0, 254));
        wr(ifc_pkg::ADDR_ALERT_LEVEL, lvl);
        rd(ifc_pkg::ADDR_ALERT_LEVEL, v);
        chk("alert level", v, lvl);
        wr(ifc_pkg::ADDR_FILL_TX, 8'h01);
        @(posedge sys_clk);
        strength <= lvl + 8'h01;
        rdbit(ifc_pkg::ADDR_FILL_TX, 2, 1'b0, "alert disabled");
        @(posedge sys_clk);
        strength <= lvl;
        wr(ifc_pkg::ADDR_FILL_TX, 8'h09);
        rdbit(ifc_pkg::ADDR_FILL_TX, 2, 1'b0, "alert at level");
        wr(ifc_pkg::ADDR_IRQ_MASK, 8'h02);
        @(posedge sys_clk);
        strength <= lvl + 8'h01;
        rdbit(ifc_pkg::ADDR_FILL_TX, 2, 1'b1, "alert above");
        chk("irq alert", irq, 1'b1);
        @(posedge sys_clk);
        strength <= 8'h00;
        rdbit(ifc_pkg::ADDR_FILL_TX, 2, 1'b1, "alert held");
        wr(ifc_pkg::ADDR_FILL_TX, 8'h0d);
        rdbit(ifc_pkg::ADDR_FILL_TX, 2, 1'b0, "alert clr");
        wr(ifc_pkg::ADDR_IRQ_STATUS, 8'h0f);
        settle(1);
        chk("irq clr", irq, 1'b0);
        // transmit finished flag, read-only
        @(posedge sys_clk);
        shiftDone <= 1'b1;
        @(posedge sys_clk);
        shiftDone <= 1'b0;
        rdbit(ifc_pkg::ADDR_FILL_TX, 5, 1'b1, "tx done");
        wr(ifc_pkg::ADDR_FILL_TX, 8'h09);
        rdbit(ifc_pkg::ADDR_FILL_TX, 5, 1'b1, "tx done ro");
        // automatic fill on sync word, rearm, overflow blocks rearm
        wr(ifc_pkg::ADDR_MODE_CFG, 8'h01);
        settle(2);
        chk("fill idle", bufFillEn, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            syncDetected <= 1'b1;
            @(posedge sys_clk);
            syncDetected <= 1'b0;
            #1;
            chk("fill on sync", bufFillEn, 1'b1);
            rdbit(ifc_pkg::ADDR_FILL_TX, 6, 1'b1, "load active");
            if (i == 1) begin
                @(posedge sys_clk);
                bufStat.overrun <= 1'b1;
                @(posedge sys_clk);
                bufStat.overrun <= 1'b0;
            end
            wr(ifc_pkg::ADDR_FILL_TX, 8'h49);
            chk("rearm", bufFillEn, logic'(i));
        end
        rdbit(ifc_pkg::ADDR_BUF_STATUS, 0, 1'b1, "overflow");
        wr(ifc_pkg::ADDR_BUF_STATUS, 8'h01);
        chk("flush", bufFlush, 1'b1);
        rdbit(ifc_pkg::ADDR_BUF_STATUS, 0, 1'b0, "overflow clr");
        rd(ifc_pkg::ADDR_IRQ_STATUS, v);
        chk("irq status", v & 8'h0c, 8'h0c);
        wr(ifc_pkg::ADDR_IRQ_STATUS, 8'h0f);
        // manual fill control; the method bit rules from the next write on
        wr(ifc_pkg::ADDR_FILL_TX, 8'h89);
        chk("auto kept", bufFillEn, 1'b1);
        wr(ifc_pkg::ADDR_FILL_TX, 8'h89);
        chk("manual stop", bufFillEn, 1'b0);
        wr(ifc_pkg::ADDR_FILL_TX, 8'hc9);
        chk("manual start", bufFillEn, 1'b1);
        wr(ifc_pkg::ADDR_MODE_CFG, 8'h00);
        chk("manual cont", bufFillEn, 1'b0);
        // launch condition and pin zero over every mode
        setting = 8'($urandom_range(2, 63));
        wr(ifc_pkg::ADDR_BUF_LEVEL, setting);
        @(posedge sys_clk);
        txMode <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(ifc_pkg::ADDR_MODE_CFG, 8'(m));
            for (int l = 0; l < 2; l++) begin
                wr(ifc_pkg::ADDR_FILL_TX, {3'b000, l[0], 4'b1001});
                for (int k = 0; k < 5; k++) begin
                    c = (k == 0) ? 0 : (k == 1) ? int'(setting) - 1 :
                        (k == 2) ? int'(setting) : (k == 3) ? 64 :
                        $urandom_range(1, 63);
                    set_count(c);
                    settle(2);
                    e = exp_launch(m, l, c, int'(setting));
                    chk("txStart", txStart, e[1]);
                    chk("irq0", irq0, e[0]);
                end
            end
        end
        @(posedge sys_clk);
        txMode <= 1'b0;
        settle(2);
        chk("txStart idle", txStart, 1'b0);
        tally_and_finish();
    end

endmodule : irq_status_fifo_fill_control_tb_top
